// ### logic/wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // Clock and tick timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 8;

    // ------------------------------------------------------------
    // Watchdog periods, in microseconds as printed, then in cycles
    // ------------------------------------------------------------
    localparam int WDT_PERIOD0_US = 1400;
    localparam int WDT_PERIOD1_US = 5500;
    localparam int WDT_PERIOD2_US = 22000;
    localparam int WDT_PERIOD3_US = 66000;
    localparam int WDT_PERIOD0_CYCLES = WDT_PERIOD0_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_PERIOD1_CYCLES = WDT_PERIOD1_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_PERIOD2_CYCLES = WDT_PERIOD2_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_PERIOD3_CYCLES = WDT_PERIOD3_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_CNT_W          = 24;

    // Length of the processor reset pulse after a watchdog expiry
    localparam int CPU_RESET_CYCLES = 16;
    localparam int CPU_RESET_W      = 5;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] WDT_CTRL_IDX   = 16'hc00c;
    localparam logic [15:0] TIMER0_IDX     = 16'hc010;
    localparam logic [15:0] TIMER1_IDX     = 16'hc012;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'hc020;
    localparam logic [15:0] IRQ_CLEAR_IDX  = 16'hc021;
    localparam logic [15:0] IRQ_ENABLE_IDX = 16'hc022;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int WDT_RESTART_BIT = 0;
    localparam int WDT_RUN_BIT     = 1;
    localparam int WDT_LOCK_BIT    = 2;
    localparam int WDT_PERIOD_LSB  = 3;
    localparam int WDT_FLAG_BIT    = 5;

    localparam logic [15:0] TIMER_RESET = 16'hffff;

    localparam int IRQ_WDT_BIT = 0;
    localparam int IRQ_T0_BIT  = 1;
    localparam int IRQ_T1_BIT  = 2;
    localparam int IRQ_W       = 3;

    typedef struct packed {
        logic [1:0] period;
        logic       lock;
        logic       watchdog_run_enable;
    } wdt_ctrl_s;

endpackage

// ### logic/wdt_top.sv
`timescale 1ns/1ps

module wdt_top #(
    parameter int WDT_P0_CYCLES = wdt_pkg::WDT_PERIOD0_CYCLES,
    parameter int WDT_P1_CYCLES = wdt_pkg::WDT_PERIOD1_CYCLES,
    parameter int WDT_P2_CYCLES = wdt_pkg::WDT_PERIOD2_CYCLES,
    parameter int WDT_P3_CYCLES = wdt_pkg::WDT_PERIOD3_CYCLES,
    parameter int TIMER_W       = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             cpu_reset
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic                       setup_phase;
    logic                       access_done;
    logic                       hit_wdt;
    logic                       hit_t0;
    logic                       hit_t1;
    logic                       hit_status;
    logic                       hit_clear;
    logic                       hit_enable;
    logic                       mapped;
    logic                       wr_wdt;
    logic                       wr_clear;
    logic                       wr_enable;
    logic [1:0]                 wr_timer;
    logic [31:0]                read_word;

    // Registered state and the combinational control derived from it
    wdt_pkg::wdt_ctrl_s         ctrl;
    logic                       flag;
    logic [wdt_pkg::WDT_CNT_W-1:0]   wdt_cnt;
    logic [wdt_pkg::WDT_CNT_W-1:0]   wdt_limit;
    logic                       wdt_active;
    logic                       restart;
    logic                       timeout;
    logic [wdt_pkg::CPU_RESET_W-1:0] rst_cnt;
    logic [wdt_pkg::TICK_W-1:0] tick_div;
    logic                       tick;
    logic [TIMER_W-1:0]         timer_cnt [2];
    logic [wdt_pkg::IRQ_W-1:0]  irq_status;
    logic [wdt_pkg::IRQ_W-1:0]  irq_enable;
    logic [wdt_pkg::IRQ_W-1:0]  irq_set;
    logic [wdt_pkg::IRQ_W-1:0]  next_irq_status;

    // Zero-wait slave: ready rises in the cycle after setup
    assign setup_phase = psel & ~penable & ~pready;
    assign access_done = psel & penable & pready;

    assign hit_wdt    = (paddr == {14'h0000, wdt_pkg::WDT_CTRL_IDX, 2'b00});
    assign hit_t0     = (paddr == {14'h0000, wdt_pkg::TIMER0_IDX, 2'b00});
    assign hit_t1     = (paddr == {14'h0000, wdt_pkg::TIMER1_IDX, 2'b00});
    assign hit_status = (paddr == {14'h0000, wdt_pkg::IRQ_STATUS_IDX, 2'b00});
    assign hit_clear  = (paddr == {14'h0000, wdt_pkg::IRQ_CLEAR_IDX, 2'b00});
    assign hit_enable = (paddr == {14'h0000, wdt_pkg::IRQ_ENABLE_IDX, 2'b00});
    assign mapped     = hit_wdt | hit_t0 | hit_t1 | hit_status | hit_clear | hit_enable;

    // Writes take effect only at the completing access edge
    assign wr_wdt      = access_done & pwrite & hit_wdt;
    assign wr_clear    = access_done & pwrite & hit_clear;
    assign wr_enable   = access_done & pwrite & hit_enable;
    assign wr_timer[0] = access_done & pwrite & hit_t0;
    assign wr_timer[1] = access_done & pwrite & hit_t1;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (hit_wdt)
        begin
            // Restart bit is write-only and reads zero; reserved bits read zero
            read_word[wdt_pkg::WDT_RUN_BIT]    = ctrl.watchdog_run_enable;
            read_word[wdt_pkg::WDT_LOCK_BIT]   = ctrl.lock;
            read_word[wdt_pkg::WDT_PERIOD_LSB +: 2] = ctrl.period;
            read_word[wdt_pkg::WDT_FLAG_BIT]   = flag;
        end
        else if (hit_t0)
        begin
            read_word[TIMER_W-1:0] = timer_cnt[0];
        end
        else if (hit_t1)
        begin
            read_word[TIMER_W-1:0] = timer_cnt[1];
        end
        else if (hit_status)
        begin
            read_word[wdt_pkg::IRQ_W-1:0] = irq_status;
        end
        else if (hit_enable)
        begin
            read_word[wdt_pkg::IRQ_W-1:0] = irq_enable;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata  <= (setup_phase & ~pwrite) ? read_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // One microsecond tick
    // ------------------------------------------------------------
    // Runs from the bus clock, so processor speed changes never touch it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_div <= '0;
            tick     <= 1'b0;
        end
        else if (tick_div == wdt_pkg::TICK_W'(wdt_pkg::TICK_CYCLES - 1))
        begin
            tick_div <= '0;
            tick     <= 1'b1;
        end
        else
        begin
            tick_div <= tick_div + 1'b1;
            tick     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Watchdog control
    // ------------------------------------------------------------
    // Lock keeps the dog alive even with run cleared
    assign wdt_active = ctrl.watchdog_run_enable | ctrl.lock;

    // Restart is honoured while locked; otherwise a locked dog could never be fed
    assign restart = wr_wdt & pwdata[wdt_pkg::WDT_RESTART_BIT];

    always_comb
    begin
        unique case (ctrl.period)
            2'b00: wdt_limit = wdt_pkg::WDT_CNT_W'(WDT_P0_CYCLES - 1);
            2'b01: wdt_limit = wdt_pkg::WDT_CNT_W'(WDT_P1_CYCLES - 1);
            2'b10: wdt_limit = wdt_pkg::WDT_CNT_W'(WDT_P2_CYCLES - 1);
            2'b11: wdt_limit = wdt_pkg::WDT_CNT_W'(WDT_P3_CYCLES - 1);
        endcase
    end

    assign timeout = wdt_active & ~restart & (wdt_cnt == wdt_limit);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= '0;
        end
        else if (timeout)
        begin
            // The processor reset also returns the dog to its idle setup
            ctrl <= '0;
        end
        else if (wr_wdt && !ctrl.lock)
        begin
            ctrl.watchdog_run_enable <= pwdata[wdt_pkg::WDT_RUN_BIT];
            ctrl.lock   <= pwdata[wdt_pkg::WDT_LOCK_BIT];
            ctrl.period <= pwdata[wdt_pkg::WDT_PERIOD_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_cnt <= '0;
        end
        else if (!wdt_active || restart || timeout)
        begin
            wdt_cnt <= '0;
        end
        else
        begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end

    // Flag is writable by nobody; only presetn clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag <= 1'b0;
        end
        else if (timeout)
        begin
            flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Processor reset pulse
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt   <= '0;
            cpu_reset <= 1'b0;
        end
        else if (timeout)
        begin
            rst_cnt   <= wdt_pkg::CPU_RESET_W'(wdt_pkg::CPU_RESET_CYCLES);
            cpu_reset <= 1'b1;
        end
        else
        begin
            if (rst_cnt != '0)
            begin
                rst_cnt <= rst_cnt - 1'b1;
            end
            cpu_reset <= (rst_cnt > wdt_pkg::CPU_RESET_W'(1));
        end
    end

    // ------------------------------------------------------------
    // General timers
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_timer
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                timer_cnt[i] <= TIMER_W'(wdt_pkg::TIMER_RESET);
            end
            else if (wr_timer[i])
            begin
                // A load beats a tick in the same cycle
                timer_cnt[i] <= pwdata[TIMER_W-1:0];
            end
            else if (tick && timer_cnt[i] != '0)
            begin
                timer_cnt[i] <= timer_cnt[i] - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------
    always_comb
    begin
        irq_set                       = '0;
        irq_set[wdt_pkg::IRQ_WDT_BIT] = timeout;
        // Level source: a timer parked at zero re-asserts after a clear
        irq_set[wdt_pkg::IRQ_T0_BIT]  = (timer_cnt[0] == '0);
        irq_set[wdt_pkg::IRQ_T1_BIT]  = (timer_cnt[1] == '0);
        next_irq_status = irq_status;
        if (wr_clear)
        begin
            next_irq_status = irq_status & ~pwdata[wdt_pkg::IRQ_W-1:0];
        end
        // Set wins over a clear in the same cycle
        next_irq_status = next_irq_status | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= '0;
        end
        else
        begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable <= '0;
        end
        else if (wr_enable)
        begin
            irq_enable <= pwdata[wdt_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_irq_status & (wr_enable ? pwdata[wdt_pkg::IRQ_W-1:0] : irq_enable));
        end
    end

endmodule

// ### verification/test_watchdog_and_dual_timers.sv
`timescale 1ns/1ps

module test_watchdog_and_dual_timers;
    localparam logic [31:0] A_WDT = {14'h0, wdt_pkg::WDT_CTRL_IDX, 2'b00};
    localparam logic [31:0] A_T0  = {14'h0, wdt_pkg::TIMER0_IDX, 2'b00};
    localparam logic [31:0] A_T1  = {14'h0, wdt_pkg::TIMER1_IDX, 2'b00};
    localparam logic [31:0] A_ST  = {14'h0, wdt_pkg::IRQ_STATUS_IDX, 2'b00};
    localparam logic [31:0] A_CLR = {14'h0, wdt_pkg::IRQ_CLEAR_IDX, 2'b00};
    localparam logic [31:0] A_EN  = {14'h0, wdt_pkg::IRQ_ENABLE_IDX, 2'b00};
    localparam logic [31:0] A_BAD = 32'h0003_0034;
    localparam int          PER[4] = '{20, 40, 80, 160};

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, cpu_reset, irq_seen;
    logic [7:0]  resets;
    int          miscompares = 0, compares = 0, cycles = 0;

    wdt_top #(.WDT_P0_CYCLES(20), .WDT_P1_CYCLES(40), .WDT_P2_CYCLES(80),
        .WDT_P3_CYCLES(160), .TIMER_W(16)) u_wdt_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .cpu_reset(cpu_reset));
    wdt_cpu_model u_wdt_cpu_model (.pclk(pclk), .presetn(presetn), .irq(irq),
        .cpu_reset(cpu_reset), .resets(resets), .irq_seen(irq_seen));

    initial forever #4 pclk = ~pclk;

    task close_out;
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits on pready itself; the bench timeout cuts a hang short
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask

    task rd(input logic [31:0] a, output logic [31:0] r);
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
    endtask

    task wait_rst(input int lim, output int n);
        n = 0;
        while (cpu_reset !== 1'b1 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task t_defaults;
        logic [31:0] r;
        logic        e;
        rd(A_WDT, r);
        chk(r, 32'h0);
        rd(A_T0, r);
        chk(r, 32'hffff);
        rd(A_T1, r);
        chk(r, 32'hffff);
        rd(A_ST, r);
        chk(r, 32'h0);
        xfer(1'b0, A_BAD, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        xfer(1'b1, A_BAD, 32'h0, r, e);
        chk(e, 1'b1);
    endtask

    task t_timers;
        logic [31:0] a, r1, r2;
        int          n;
        for (int i = 0; i < 2; i++)
        begin
            a = i ? A_T1 : A_T0;
            wr(A_EN, 32'h1 << (i + 1));
            wr(a, 32'h100);
            rd(a, r1);
            repeat (122) @(posedge pclk);
            rd(a, r2);
            chk(r1 - r2, 32'h1);
            wr(a, 32'h3);
            n = 0;
            while (irq !== 1'b1 && n < 600)
            begin
                @(posedge pclk);
                n++;
            end
            chk(irq, 1'b1);
            rd(a, r1);
            chk(r1, 32'h0);
            wr(A_CLR, 32'h1 << (i + 1));
            repeat (3) @(posedge pclk);
            chk(irq, 1'b1);
            wr(a, 32'hffff);
            wr(A_CLR, 32'h1 << (i + 1));
            repeat (3) @(posedge pclk);
            chk(irq, 1'b0);
            rd(a, r1);
            chk(r1 >> 8, 32'hff);
        end
        chk(irq_seen, 1'b1);
    endtask

    task t_expiry;
        logic [31:0] r;
        logic [7:0]  c;
        int          n;
        for (int p = 0; p < 4; p++)
        begin
            wr(A_EN, 32'h1);
            c = resets;
            wr(A_WDT, (32'(p) << 3) | 32'h2);
            wait_rst(400, n);
            chk(n >= PER[p] - 3 && n <= PER[p] + 4, 1'b1);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b1);
            repeat (20) @(posedge pclk);
            rd(A_WDT, r);
            chk(r, 32'h20);
            chk(resets, c + 8'h1);
            wr(A_CLR, 32'h1);
        end
    endtask

    task t_restart;
        logic [31:0] r;
        logic [7:0]  c;
        c = resets;
        wr(A_WDT, 32'h0a);
        rd(A_WDT, r);
        chk(r, 32'h2a);
        repeat (20) wr(A_WDT, 32'h0b);
        chk(resets, c);
        wr(A_WDT, 32'h08);
        repeat (100) @(posedge pclk);
        chk(resets, c);
    endtask

    task t_lock;
        logic [31:0] r;
        int          n;
        wr(A_WDT, 32'h0c);
        wr(A_WDT, 32'h0);
        rd(A_WDT, r);
        chk(r, 32'h2c);
        wait_rst(200, n);
        chk(cpu_reset, 1'b1);
        repeat (20) @(posedge pclk);
        rd(A_WDT, r);
        chk(r, 32'h20);
        wr(A_CLR, 32'h1);
    endtask

    task t_hw_reset;
        logic [31:0] r;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_WDT, r);
        chk(r, 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults;
        t_timers;
        t_expiry;
        t_restart;
        t_lock;
        t_hw_reset;
        close_out;
    end
endmodule

// ### verification/wdt_checker.sv
`timescale 1ns/1ps

// ----------------------------------------
// Bus timing and reset pulse checks
// ----------------------------------------
module wdt_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        cpu_reset
);
    logic [5:0] hi_cnt;
    logic       hit;

    assign hit = paddr[31:18] == 14'h0 && paddr[1:0] == 2'b00 && (paddr[17:2] inside
        {wdt_pkg::WDT_CTRL_IDX, wdt_pkg::TIMER0_IDX, wdt_pkg::TIMER1_IDX,
        wdt_pkg::IRQ_STATUS_IDX, wdt_pkg::IRQ_CLEAR_IDX, wdt_pkg::IRQ_ENABLE_IDX});

    // Pulse length counted here, since a repetition of 16 is too long to unroll
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            hi_cnt <= 6'h0;
        else
            hi_cnt <= cpu_reset ? hi_cnt + 6'h1 : 6'h0;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_unmapped_error: assert property (pready && !hit |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_no_error: assert property (pready && hit |-> !pslverr)
        else $error("error on mapped address");
    a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_pulse_length: assert property ($fell(cpu_reset) |-> hi_cnt == 6'h10)
        else $error("reset pulse length wrong");
    a_pulse_bound: assert property (cpu_reset |-> hi_cnt < 6'h10)
        else $error("reset pulse too long");

    c_cpu_reset: cover property ($rose(cpu_reset));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (pready && pslverr);
endmodule

bind wdt_top wdt_checker u_wdt_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .cpu_reset(cpu_reset));

// ### verification/wdt_cpu_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Processor reset and interrupt inputs
// ----------------------------------------
module wdt_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq,
    input  wire logic       cpu_reset,
    output logic      [7:0] resets,
    output logic            irq_seen
);
    logic was_reset;

    // Counts pulses, not cycles: one long pulse is one restart
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            resets    <= 8'h0;
            was_reset <= 1'b0;
            irq_seen  <= 1'b0;
        end
        else
        begin
            was_reset <= cpu_reset;
            irq_seen  <= irq_seen | irq;
            if (cpu_reset && !was_reset)
                resets <= resets + 8'h1;
        end
endmodule
